// ---- core/tcp_channel.sv ----
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "tcp_params.svh"
module tcp_channel
  import tcp_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic                     count_en,
  input  wire logic                     capture_in,
  input  wire logic                     quad_a,
  input  wire logic                     quad_b,
  input  wire logic                     kill_in,
  input  wire logic [`TCP_ADDR_W-1:0]   addr,
  input  wire logic [31:0]              wdata,
  input  wire logic                     wr,
  input  wire logic                     rd,
  output logic      [31:0]              rdata,
  output logic                          pwm_true,
  output logic                          pwm_comp,
  output logic                          tc_pulse
);

  tcp_state_s s;
  tcp_state_s nx;

  // width mask for narrow channels
  function automatic logic [31:0] fit(input logic [31:0] v, input logic wide);
    fit = wide ? v : (v & `TCP_NARROW_MASK);
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    logic [31:0] cnt_n;
    logic        wide;
    logic        run;
    logic        cap_ev;
    logic        qa_e;
    logic        qb_e;
    logic        raw;
    logic        fb;
    logic        kill;
    logic        pwm_mode;
    logic [15:0] dt_len;
    tcp_mode_e   mode;
    nx       = s;
    wide     = s.ctrl[`TCP_CTRL_WIDE];
    mode     = tcp_mode_e'(s.ctrl[`TCP_CTRL_MODE_HI:`TCP_CTRL_MODE_LO]);
    run      = s.ctrl[`TCP_CTRL_RUN] & ~s.halted;
    cnt_n    = s.count;
    raw      = s.raw_q;
    fb       = 1'b0;
    dt_len   = 16'h0000;
    nx.tc_pulse = 1'b0;
    // synchronisers for pins
    nx.cap_s  = {s.cap_s[0], capture_in};
    nx.qa_s   = {s.qa_s[0], quad_a};
    nx.qb_s   = {s.qb_s[0], quad_b};
    nx.kill_s = {s.kill_s[0], kill_in};
    nx.cap_q  = s.cap_s[1];
    nx.qa_q   = s.qa_s[1];
    nx.qb_q   = s.qb_s[1];
    cap_ev    = s.cap_s[1] & ~s.cap_q;
    qa_e      = s.qa_s[1] ^ s.qa_q;
    qb_e      = s.qb_s[1] ^ s.qb_q;
    kill      = s.kill_s[1];
    pwm_mode  = (mode == TCP_MODE_PWM) || (mode == TCP_MODE_PWM_DEADTIME) ||
                (mode == TCP_MODE_PWM_RANDOM);
    // counting per mode
    case (mode)
      TCP_MODE_QUAD: begin
        if (run && (qa_e || qb_e)) begin
          if ((s.qa_s[1] ^ s.qb_s[1]) ^ qa_e)
            cnt_n = s.count - 32'h1;
          else
            cnt_n = s.count + 32'h1;
        end
      end
      TCP_MODE_SHIFT: begin
        if (run && count_en) begin
          cnt_n = {s.count[30:0], s.qa_s[1]};
        end
      end
      default: begin
        if (run && count_en) begin
          if (s.count == s.period) begin
            nx.tc_pulse = 1'b1;
            nx.tc_flag  = 1'b1;
            cnt_n       = 32'h0;
            if (s.ctrl[`TCP_CTRL_ONESHOT]) begin
              nx.halted = 1'b1;
              cnt_n     = s.count;
            end
          end else begin
            cnt_n = s.count + 32'h1;
          end
        end
      end
    endcase
    nx.count = fit(cnt_n, wide);
    // lfsr advances on every enabled cycle while running, in every mode, quad included
    if (run && count_en) begin
      fb      = ^(s.lfsr & `TCP_LFSR_TAPS);
      nx.lfsr = {s.lfsr[30:0], fb};
    end
    // capture of count on event
    if (cap_ev && (mode == TCP_MODE_CAPTURE || mode == TCP_MODE_TIMER)) begin
      nx.capture  = s.count;
      nx.cap_flag = 1'b1;
    end
    // raw duty from compares
    if (mode == TCP_MODE_PWM_RANDOM)
      raw = fit(s.lfsr, wide) < s.cmp0;
    else if (mode == TCP_MODE_QUAD && s.ctrl[`TCP_CTRL_ENH])
      raw = (s.count >= s.cmp0) && (s.count < s.cmp1);
    else
      raw = s.count < s.cmp0;
    nx.raw_q = raw;
    // dead time length per edge
    if (mode == TCP_MODE_PWM_DEADTIME)
      dt_len = {8'h00, s.dt[7:0]};
    else if (mode == TCP_MODE_QUAD && s.ctrl[`TCP_CTRL_ENH])
      dt_len = raw ? s.dt[15:0] : s.dt[31:16];
    // outputs with offset between pair, both low for exactly dt_len cycles
    if (raw != s.raw_q && dt_len != 16'h0000) begin
      nx.line_t = 1'b0;
      nx.line_c = 1'b0;
      nx.dt_cnt = dt_len - 16'h0001;
    end else if (raw == s.raw_q && s.dt_cnt != 16'h0000) begin
      nx.dt_cnt = s.dt_cnt - 16'h0001;
    end else begin
      // zero dead time gives a plain complement
      nx.dt_cnt = 16'h0000;
      nx.line_t = raw;
      nx.line_c = ~raw;
    end
    // kill overrides in pwm modes
    if (pwm_mode && kill) begin
      nx.out_t = s.ctrl[`TCP_CTRL_KILLT];
      nx.out_c = s.ctrl[`TCP_CTRL_KILLC];
    end else if (pwm_mode || (mode == TCP_MODE_QUAD && s.ctrl[`TCP_CTRL_ENH])) begin
      nx.out_t = s.line_t;
      nx.out_c = s.line_c;
    end else begin
      nx.out_t = (mode == TCP_MODE_SHIFT) ? s.count[31] : 1'b0;
      nx.out_c = 1'b0;
    end
    // register writes
    if (wr) begin
      if (addr == `TCP_OFF_CTRL) begin
        nx.ctrl   = wdata;
        nx.halted = 1'b0;
      end else if (addr == `TCP_OFF_PERIOD) begin
        nx.period = fit(wdata, wide);
      end else if (addr == `TCP_OFF_CMP0) begin
        nx.cmp0 = fit(wdata, wide);
      end else if (addr == `TCP_OFF_CMP1) begin
        nx.cmp1 = fit(wdata, wide);
      end else if (addr == `TCP_OFF_DT) begin
        nx.dt = wdata;
      end else if (addr == `TCP_OFF_COUNT) begin
        nx.count = fit(wdata, wide);
      end else if (addr == `TCP_OFF_STATUS) begin
        // write one to clear, new event wins
        if (wdata[0] && !(cap_ev && (mode == TCP_MODE_CAPTURE || mode == TCP_MODE_TIMER)))
          nx.cap_flag = 1'b0;
        if (wdata[1] && !nx.tc_pulse)
          nx.tc_flag = 1'b0;
      end
    end
    // register reads, data next cycle
    nx.rdata = 32'h0;
    if (rd) begin
      if (addr == `TCP_OFF_CTRL)
        nx.rdata = s.ctrl;
      else if (addr == `TCP_OFF_PERIOD)
        nx.rdata = s.period;
      else if (addr == `TCP_OFF_CMP0)
        nx.rdata = s.cmp0;
      else if (addr == `TCP_OFF_CMP1)
        nx.rdata = s.cmp1;
      else if (addr == `TCP_OFF_DT)
        nx.rdata = s.dt;
      else if (addr == `TCP_OFF_COUNT)
        nx.rdata = s.count;
      else if (addr == `TCP_OFF_CAPTURE)
        nx.rdata = s.capture;
      else if (addr == `TCP_OFF_STATUS)
        nx.rdata = {28'h0, kill, s.halted, s.tc_flag, s.cap_flag};
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s        <= '0;
      s.period <= `TCP_PERIOD_RST;
      s.lfsr   <= `TCP_LFSR_SEED;
      s.line_c <= 1'b1;
    end else begin
      s <= nx;
    end
  end

  // outputs straight from flops
  assign rdata    = s.rdata;
  assign pwm_true = s.out_t;
  assign pwm_comp = s.out_c;
  assign tc_pulse = s.tc_pulse;

endmodule

// ---- core/tcp_params.svh ----
`ifndef TCP_PARAMS_SVH
`define TCP_PARAMS_SVH
// ==========================================================
// register offsets
`define TCP_ADDR_W       5
`define TCP_OFF_CTRL     5'h00
`define TCP_OFF_PERIOD   5'h04
`define TCP_OFF_CMP0     5'h08
`define TCP_OFF_CMP1     5'h0c
`define TCP_OFF_DT       5'h10
`define TCP_OFF_COUNT    5'h14
`define TCP_OFF_CAPTURE  5'h18
`define TCP_OFF_STATUS   5'h1c
// ==========================================================
// control fields
`define TCP_CTRL_RUN     0
`define TCP_CTRL_ONESHOT 1
`define TCP_CTRL_MODE_LO 2
`define TCP_CTRL_MODE_HI 4
`define TCP_CTRL_WIDE    5
`define TCP_CTRL_KILLT   6
`define TCP_CTRL_KILLC   7
`define TCP_CTRL_ENH     8
// ==========================================================
// reset values and widths
`define TCP_W            32
`define TCP_NARROW_MASK  32'h0000ffff
`define TCP_PERIOD_RST   32'h0000ffff
`define TCP_LFSR_SEED    32'h00000001
`define TCP_LFSR_TAPS    32'h80200003
`endif

// ---- core/tcp_pkg.sv ----
package tcp_pkg;
  // ==========================================================
  // channel modes
  typedef enum logic [2:0] {
    TCP_MODE_TIMER        = 3'b000,
    TCP_MODE_CAPTURE      = 3'b001,
    TCP_MODE_QUAD         = 3'b010,
    TCP_MODE_PWM          = 3'b011,
    TCP_MODE_PWM_DEADTIME = 3'b100,
    TCP_MODE_PWM_RANDOM   = 3'b101,
    TCP_MODE_SHIFT        = 3'b110
  } tcp_mode_e;

  // all state of the channel
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] period;
    logic [31:0] cmp0;
    logic [31:0] cmp1;
    logic [31:0] dt;
    logic [31:0] count;
    logic [31:0] capture;
    logic [31:0] lfsr;
    logic [15:0] dt_cnt;
    logic        raw_q;
    logic        line_t;
    logic        line_c;
    logic        halted;
    logic        cap_flag;
    logic        tc_flag;
    logic [1:0]  cap_s;
    logic        cap_q;
    logic [1:0]  qa_s;
    logic [1:0]  qb_s;
    logic        qa_q;
    logic        qb_q;
    logic [1:0]  kill_s;
    logic [31:0] rdata;
    logic        out_t;
    logic        out_c;
    logic        tc_pulse;
  } tcp_state_s;
endpackage

// ---- testbench/tcp_channel_test.sv ----
`timescale 1ns/1ps
`include "tcp_params.svh"
module tcp_channel_test import tcp_pkg::*;;
  logic        clk = 1'b0, resetn = 1'b0, count_en = 1'b0, wr = 1'b0, rd = 1'b0;
  logic        fault = 1'b0, step = 1'b0, half = 1'b0, cap = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic        kill_in, quad_a, quad_b, pwm_true, pwm_comp, tc_pulse;
  int          fail_count = 0, cmp_count = 0, cyc = 0, gap;
  logic [31:0] n_t, n_c;
  logic [68:0] rows [5] = '{{5'h04, 32'h12345678, 32'h12345678}, {5'h08, 32'h7, 32'h7},
    {5'h0c, 32'h89abcdef, 32'h89abcdef}, {5'h10, 32'h30002, 32'h30002}, {5'h02, 32'h1, 32'h0}};
  logic [74:0] pw [4] = '{{3'h3, 32'h4, 32'h0, 4'h4, 4'h6}, {3'h4, 32'h4, 32'h102, 4'h2, 4'h4},
    {3'h5, 32'h0, 32'h0, 4'h0, 4'ha}, {3'h5, 32'hffffffff, 32'h0, 4'ha, 4'h0}};
  logic [4:0]  en [3] = '{5'h07, 5'h0e, 5'h02};
  // ==========================================================
  // clock, enable, timeout
  always #12.5 clk = ~clk;
  always @(posedge clk) count_en <= half ? !count_en : 1'b1;
  always @(posedge clk) if (++cyc == 20000) begin
    fail_count++;
    tally_and_finish();
  end
  tcp_channel i_dut (.clk(clk), .resetn(resetn), .count_en(count_en), .capture_in(cap),
    .quad_a(quad_a), .quad_b(quad_b), .kill_in(kill_in), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .pwm_true(pwm_true), .pwm_comp(pwm_comp), .tc_pulse(tc_pulse));
  tcp_partner i_far (.clk(clk), .fault(fault), .step(step), .kill_in(kill_in),
    .quad_a(quad_a), .quad_b(quad_b));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one bus cycle, read data taken in the cycle after the strobe
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic put(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(v, e);
  endtask
  task automatic tc_gap();
    gap = 0;
    do begin @(posedge clk); #1; end while (tc_pulse !== 1'b1);
    do begin @(posedge clk); #1 gap++; end while (tc_pulse !== 1'b1);
  endtask
  // encoder steps, spaced so each pin change clears the synchroniser
  task automatic steps(input int n);
    repeat (n) begin
      step <= 1'b1;
      @(posedge clk);
      step <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    chk({pwm_true, pwm_comp, tc_pulse}, 32'h0);
    rdchk(`TCP_OFF_PERIOD, `TCP_PERIOD_RST);
    put(`TCP_OFF_CTRL, 32'h20);
    foreach (rows[i]) begin
      put(rows[i][68:64], rows[i][63:32]);
      rdchk(rows[i][68:64], rows[i][31:0]);
    end
    put(`TCP_OFF_CTRL, 32'h0);
    put(`TCP_OFF_COUNT, 32'h10003);
    @(posedge clk);
    rd <= 1'b1;
    addr <= `TCP_OFF_COUNT;
    repeat (2) @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, 32'h3);
    put(`TCP_OFF_PERIOD, 32'h5);
    put(`TCP_OFF_COUNT, 32'h0);
    put(`TCP_OFF_CTRL, 32'h3);
    repeat (20) @(posedge clk);
    rdchk(`TCP_OFF_COUNT, 32'h5);
    put(`TCP_OFF_CTRL, 32'h1);
    tc_gap();
    chk(gap, 32'h6);
    half <= 1'b1;
    tc_gap();
    chk(gap, 32'hc);
    half <= 1'b0;
    put(`TCP_OFF_CTRL, 32'h4);
    put(`TCP_OFF_COUNT, 32'h2a);
    cap <= 1'b1;
    repeat (2) @(posedge clk);
    cap <= 1'b0;
    repeat (6) @(posedge clk);
    rdchk(`TCP_OFF_CAPTURE, 32'h2a);
    put(`TCP_OFF_PERIOD, 32'h9);
    put(`TCP_OFF_COUNT, 32'h0);
    foreach (pw[i]) begin
      put(`TCP_OFF_CMP0, pw[i][71:40]);
      put(`TCP_OFF_DT, pw[i][39:8]);
      put(`TCP_OFF_CTRL, {27'h1, pw[i][74:72], 2'h1});
      repeat (30) @(posedge clk);
      n_t = 0;
      n_c = 0;
      repeat (10) begin
        @(posedge clk);
        #1 n_t += pwm_true;
        n_c += pwm_comp;
      end
      chk(n_t, pw[i][7:4]);
      chk(n_c, pw[i][3:0]);
    end
    put(`TCP_OFF_CMP0, 32'h80000000);
    put(`TCP_OFF_CTRL, 32'h35);
    repeat (30) @(posedge clk);
    n_t = 32'h0;
    repeat (40) begin
      @(posedge clk);
      #1 n_t += pwm_true;
    end
    chk({31'h0, n_t != 32'h0 && n_t != 32'h28}, 32'h1);
    put(`TCP_OFF_CMP1, 32'h6);
    put(`TCP_OFF_CMP0, 32'h2);
    put(`TCP_OFF_DT, 32'h0);
    put(`TCP_OFF_CTRL, 32'h109);
    foreach (en[i]) begin
      put(`TCP_OFF_COUNT, en[i][4:1]);
      repeat (8) @(posedge clk);
      #1 chk(pwm_true, en[i][0]);
    end
    put(`TCP_OFF_COUNT, 32'h0);
    steps(4);
    bus(1'b0, `TCP_OFF_COUNT, 32'h0);
    chk({31'h0, v == 32'h4 || v == 32'hfffc}, 32'h1);
    steps(2);
    put(`TCP_OFF_COUNT, 32'h0);
    put(`TCP_OFF_CTRL, 32'h19);
    repeat (20) @(posedge clk);
    rdchk(`TCP_OFF_COUNT, 32'hffff);
    put(`TCP_OFF_CTRL, 32'h4d);
    fault <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chk({pwm_true, pwm_comp}, 32'h2);
    #3 resetn = 1'b0;
    #1 chk({pwm_true, pwm_comp}, 32'h0);
    fault <= 1'b0;
    @(posedge clk);
    resetn <= 1'b1;
    rdchk(`TCP_OFF_CTRL, 32'h0);
    tally_and_finish();
  end
endmodule
bind tcp_channel tcp_monitor i_mon (.clk(clk), .resetn(resetn), .count_en(count_en),
  .kill_in(kill_in), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .pwm_true(pwm_true), .pwm_comp(pwm_comp), .tc_pulse(tc_pulse));

// ---- testbench/tcp_monitor.sv ----
`timescale 1ns/1ps
`include "tcp_params.svh"
module tcp_monitor
  import tcp_pkg::*;
(
  input wire logic                   clk,
  input wire logic                   resetn,
  input wire logic                   count_en,
  input wire logic                   kill_in,
  input wire logic [`TCP_ADDR_W-1:0] addr,
  input wire logic [31:0]            wdata,
  input wire logic                   wr,
  input wire logic                   rd,
  input wire logic [31:0]            rdata,
  input wire logic                   pwm_true,
  input wire logic                   pwm_comp,
  input wire logic                   tc_pulse
);
  // ==========================================================
  // control shadow and checks
  logic [8:0] sh;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) sh <= 9'h000;
    else if (wr && addr == `TCP_OFF_CTRL) sh <= wdata[8:0];
  end
  function automatic logic tc_ok(logic [8:0] c);
    return c[0] && c[4:2] inside {TCP_MODE_TIMER, TCP_MODE_CAPTURE, TCP_MODE_PWM,
                                  TCP_MODE_PWM_DEADTIME, TCP_MODE_PWM_RANDOM};
  endfunction
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence cnt_rd; rd && addr == `TCP_OFF_COUNT; endsequence
  sequence killed; (kill_in && !wr)[*4] ##0 sh[4:2] inside {3'h3, 3'h4, 3'h5}; endsequence
  sequence clear; (!kill_in)[*4] ##0 sh[4:2] inside {3'h3, 3'h4, 3'h5}; endsequence
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0) else $error("rdata not idle");
  ctrl_read_a: assert property (rd && addr == `TCP_OFF_CTRL |=> rdata[8:0] == $past(sh))
    else $error("control readback wrong");
  narrow_count_a: assert property (cnt_rd ##0 !sh[5] |=> rdata[31:16] == 16'h0)
    else $error("narrow count not masked");
  count_hold_a: assert property ((cnt_rd ##0 !sh[0] && !wr && sh[4:2] inside {3'h0, 3'h3})
    ##1 cnt_rd |=> rdata == $past(rdata)) else $error("stopped count moved");
  tc_cause_a: assert property (tc_pulse |-> tc_ok($past(sh)) || tc_ok($past(sh, 2)))
    else $error("tc pulse without running count");
  tc_enable_a: assert property (tc_pulse |-> $past(count_en))
    else $error("tc pulse without enable");
  kill_safe_a: assert property (killed |-> pwm_true == sh[6] && pwm_comp == sh[7])
    else $error("kill did not force outputs");
  pair_excl_a: assert property (clear |-> !(pwm_true && pwm_comp))
    else $error("both outputs high");
endmodule

// ---- testbench/tcp_partner.sv ----
`timescale 1ns/1ps
module tcp_partner (
  input  wire logic clk,
  input  wire logic fault,
  input  wire logic step,
  output logic      kill_in,
  output logic      quad_a,
  output logic      quad_b
);
  logic [1:0] ph = 2'h0;
  // encoder phases advance one state per step
  always_ff @(posedge clk) if (step) ph <= ph + 2'h1;
  // protection trips kill at once on a fault
  assign kill_in = fault;
  assign quad_a  = ph[1];
  assign quad_b  = ph[1] ^ ph[0];
endmodule
